// File: ofs_defines.vh
// Register map, field layout, reset values and function codes of the selector
`ifndef OFS_DEFINES_VH
`define OFS_DEFINES_VH

// Register byte offsets on the AXI4-Lite slave
`define OFS_REG_SEL_MAIN 8'h00
`define OFS_REG_SEL_TR 8'h04
`define OFS_REG_SEL_EXT_A 8'h08
`define OFS_REG_SEL_EXT_B 8'h0C
`define OFS_REG_DET_FREQ 8'h10
`define OFS_REG_DET_BAND 8'h14
`define OFS_REG_STATUS 8'h18

// Field widths
`define OFS_SEL_W 6
`define OFS_FREQ_W 16
`define OFS_NUM_OUT 4

// Status register field positions
`define OFS_ST_OUT_LSB 0
`define OFS_ST_REACH_BIT 4

// Reset values: main relay trips, transistor shows run, extensions idle
`define OFS_RST_SEL_MAIN 6'h1D
`define OFS_RST_SEL_TR 6'h0E
`define OFS_RST_SEL_EXT_A 6'h00
`define OFS_RST_SEL_EXT_B 6'h00
// Detection frequency 30.00 Hz and band 10.00 Hz, in 0.01 Hz
`define OFS_RST_DET_FREQ 16'h0BB8
`define OFS_RST_DET_BAND 16'h03E8

// Selection codes with a function in this block
`define OFS_FN_NONE 6'h00
`define OFS_FN_FDT4 6'h04
`define OFS_FN_OVERLOAD 6'h05
`define OFS_FN_INV_OVL 6'h06
`define OFS_FN_UNDERLOAD 6'h07
`define OFS_FN_FAN 6'h08
`define OFS_FN_STALL 6'h09
`define OFS_FN_OVER_V 6'h0A
`define OFS_FN_LOW_V 6'h0B
`define OFS_FN_OVERHEAT 6'h0C
`define OFS_FN_LOST_CMD 6'h0D
`define OFS_FN_RUN 6'h0E
`define OFS_FN_STOP 6'h0F
`define OFS_FN_STEADY 6'h10
`define OFS_FN_DRIVE_LINE 6'h11
`define OFS_FN_MAINS_LINE 6'h12
`define OFS_FN_SPD_SEARCH 6'h13
`define OFS_FN_READY 6'h16
`define OFS_FN_TIMER 6'h1C
`define OFS_FN_TRIP 6'h1D
`define OFS_FN_ONOFF 6'h22
// Width of the condition vector, one bit per code up to the last one
`define OFS_FN_NUM 35

// AXI response codes
`define OFS_RESP_OKAY 2'h0
`define OFS_RESP_SLVERR 2'h2

`endif

// File: ofs_sel.v
// Per-output decoder: picks one condition by its selection code
`include "ofs_defines.vh"

module ofs_sel #(
	parameter SEL_W = `OFS_SEL_W,
	parameter FN_NUM = `OFS_FN_NUM
) (
	input wire [SEL_W-1:0] sel_code,
	input wire [FN_NUM-1:0] cond_vec,
	output reg sel_out
);

	// Vector slot index of the code, widened to compare against FN_NUM
	wire [31:0] code_idx;
	assign code_idx = {{(32-SEL_W){1'b0}}, sel_code};

	////////////////////////////////////////////////////////////////////
	// Indexed pick; codes past the table fall to zero
	always @* begin
		// [RQ1] Shared code table
		if (code_idx < FN_NUM) begin
			sel_out = cond_vec[code_idx];
		end else begin
			// [RQ23] Unknown code off
			sel_out = 1'b0;
		end
	end

endmodule // ofs_sel

// File: ofs_top.v
// Output function selector: AXI4-Lite registers, conditions, output flops
//
// Operation
// [RQ1] One code table, each output own code
// [RQ2] Accelerating: on when frequency reaches detection
// [RQ3] Decelerating: on above detection minus half band
// [RQ4] Code 5 follows motor overload
// [RQ5] Code 6 follows inverse-time overload fault
// [RQ6] Code 7 follows underload warning
// [RQ7] Code 8 follows fan fault warning
// [RQ8] Code 9 on when overloaded and stalled
// [RQ9] Code 10 on at DC overvoltage
// [RQ10] Code 11 on at DC low voltage
// [RQ11] Code 12 follows drive overheat
// [RQ12] Code 13 on at any lost command
// [RQ13] Code 14 running with voltage, not braking
// [RQ14] Code 15 run off and no voltage
// [RQ15] Code 16 running at steady speed
// [RQ16] Code 17 motor on drive line
// [RQ17] Code 18 motor on mains source
// [RQ18] Code 19 during speed search
// [RQ19] Code 22 standby, ready for run command
// [RQ20] Code 28 follows input delay timer
// [RQ21] Code 29 on after fault trip
// [RQ22] Code 34 follows analog on/off compare
// [RQ23] Undefined codes hold output off
//
// Decided for this implementation: the placing of the registers and register access over AXI4-Lite.
`include "ofs_defines.vh"

module ofs_top #(
	parameter ADDR_W = 8,
	parameter SEL_W = `OFS_SEL_W,
	parameter FREQ_W = `OFS_FREQ_W
) (
	input wire aclk,
	input wire aresetn,
	// AXI4-Lite write address
	input wire [ADDR_W-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	// AXI4-Lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	// AXI4-Lite write response
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	// AXI4-Lite read address
	input wire [ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	// AXI4-Lite read data
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	// Drive state from the detectors
	input wire [FREQ_W-1:0] op_freq,
	input wire accelerating,
	input wire decelerating,
	input wire motor_overload,
	input wire inv_time_overload_fault,
	input wire underload_warn,
	input wire fan_warn,
	input wire stall,
	input wire dc_over_voltage,
	input wire dc_low_voltage,
	input wire drive_overheat,
	input wire analog_cmd_lost,
	input wire comm_cmd_lost,
	input wire option_cmd_lost,
	input wire run_cmd,
	input wire output_voltage_on,
	input wire dc_braking,
	input wire motor_on_drive_line,
	input wire motor_on_mains,
	input wire speed_search_active,
	input wire ready_standby,
	input wire io_timer_out,
	input wire fault_tripped,
	input wire analog_onoff_out,
	// Digital outputs, high means energised
	output wire main_relay,
	output wire open_collector_output,
	output wire ext_relay_a,
	output wire ext_relay_b
);

	localparam N = `OFS_NUM_OUT;
	localparam FN_NUM = `OFS_FN_NUM;
	// Reset codes packed per output, output 0 in the low slice
	localparam [N*SEL_W-1:0] RST_SEL = {`OFS_RST_SEL_EXT_B,
		`OFS_RST_SEL_EXT_A, `OFS_RST_SEL_TR, `OFS_RST_SEL_MAIN};

	////////////////////////////////////////////////////////////////////
	// Bus state
	reg awready_ff; // Write address slot free
	reg wready_ff; // Write data slot free
	reg aw_full_ff; // Write address held
	reg w_full_ff; // Write data held
	reg [ADDR_W-1:0] aw_addr_ff; // Held write address
	reg [31:0] w_data_ff; // Held write data
	reg [3:0] w_strb_ff; // Held byte enables
	reg bvalid_ff; // Write answer pending
	reg [1:0] bresp_ff; // Write answer code
	reg arready_ff; // Read slot free
	reg rvalid_ff; // Read answer pending
	reg [31:0] rdata_ff; // Read answer data
	reg [1:0] rresp_ff; // Read answer code

	// Configuration and state
	reg [FREQ_W-1:0] det_freq_ff; // Detection frequency
	reg [FREQ_W-1:0] det_band_ff; // Detection band
	reg reach_ff; // Frequency reach with hysteresis
	wire [SEL_W-1:0] sel_w [0:N-1]; // Codes of each output
	wire [N-1:0] out_vec; // Output flop levels

	////////////////////////////////////////////////////////////////////
	// Write decode, done once both halves are held
	wire wr_fire;
	wire wr_sel_hit;
	wire wr_freq_hit;
	wire wr_band_hit;
	wire wr_status_hit;
	wire wr_ok;

	assign wr_fire = aw_full_ff & w_full_ff & ~bvalid_ff;
	// Selector registers fill the first four words
	assign wr_sel_hit = (aw_addr_ff[1:0] == 2'h0) &&
		(aw_addr_ff < `OFS_REG_DET_FREQ);
	assign wr_freq_hit = (aw_addr_ff == `OFS_REG_DET_FREQ);
	assign wr_band_hit = (aw_addr_ff == `OFS_REG_DET_BAND);
	// Status is read only; a write is accepted and dropped
	assign wr_status_hit = (aw_addr_ff == `OFS_REG_STATUS);
	assign wr_ok = wr_sel_hit | wr_freq_hit | wr_band_hit | wr_status_hit;

	// Byte-lane merge for the 16-bit fields
	function [15:0] merge16;
		input [15:0] old_v;
		input [15:0] new_v;
		input [1:0] strb;
		begin
			merge16[7:0] = strb[0] ? new_v[7:0] : old_v[7:0];
			merge16[15:8] = strb[1] ? new_v[15:8] : old_v[15:8];
		end
	endfunction

	////////////////////////////////////////////////////////////////////
	// Write channels: each half taken on its own, answered together
	always @(posedge aclk) begin
		if (!aresetn) begin
			awready_ff <= 1'b1;
			wready_ff <= 1'b1;
			aw_full_ff <= 1'b0;
			w_full_ff <= 1'b0;
			aw_addr_ff <= {ADDR_W{1'b0}};
			w_data_ff <= 32'h00000000;
			w_strb_ff <= 4'h0;
			bvalid_ff <= 1'b0;
			bresp_ff <= `OFS_RESP_OKAY;
		end else begin
			// Address half
			if (s_axi_awvalid && awready_ff) begin
				aw_addr_ff <= s_axi_awaddr;
				aw_full_ff <= 1'b1;
				awready_ff <= 1'b0;
			end
			// Data half
			if (s_axi_wvalid && wready_ff) begin
				w_data_ff <= s_axi_wdata;
				w_strb_ff <= s_axi_wstrb;
				w_full_ff <= 1'b1;
				wready_ff <= 1'b0;
			end
			// Both held: commit and answer
			if (wr_fire) begin
				aw_full_ff <= 1'b0;
				w_full_ff <= 1'b0;
				bvalid_ff <= 1'b1;
				bresp_ff <= wr_ok ? `OFS_RESP_OKAY : `OFS_RESP_SLVERR;
			end
			// Answer taken: reopen both slots
			if (bvalid_ff && s_axi_bready) begin
				bvalid_ff <= 1'b0;
				awready_ff <= 1'b1;
				wready_ff <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Detection settings, byte lanes honoured
	always @(posedge aclk) begin
		if (!aresetn) begin
			det_freq_ff <= `OFS_RST_DET_FREQ;
			det_band_ff <= `OFS_RST_DET_BAND;
		end else if (wr_fire) begin
			if (wr_freq_hit) begin
				det_freq_ff <= merge16(det_freq_ff, w_data_ff[15:0],
					w_strb_ff[1:0]);
			end
			if (wr_band_hit) begin
				det_band_ff <= merge16(det_band_ff, w_data_ff[15:0],
					w_strb_ff[1:0]);
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Frequency reach with hysteresis
	// Compare op + band/2 against detection so nothing underflows
	wire [FREQ_W:0] op_plus_half;
	wire reach_acc;
	wire reach_dec;
	assign op_plus_half = {1'b0, op_freq} +
		{2'b00, det_band_ff[FREQ_W-1:1]};
	assign reach_acc = (op_freq >= det_freq_ff);
	assign reach_dec = (op_plus_half > {1'b0, det_freq_ff});

	// Steady speed holds the last decision, so no chatter at the edge
	always @(posedge aclk) begin
		if (!aresetn) begin
			reach_ff <= 1'b0;
		end else if (accelerating) begin
			// [RQ2] Rising threshold compare
			reach_ff <= reach_acc;
		end else if (decelerating) begin
			// [RQ3] Falling threshold with half band
			reach_ff <= reach_dec;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Condition vector, slot number equals selection code
	reg [FN_NUM-1:0] cond_vec;
	always @* begin
		cond_vec = {FN_NUM{1'b0}};
		cond_vec[`OFS_FN_FDT4] = reach_ff;
		// [RQ4] Motor overload flag
		cond_vec[`OFS_FN_OVERLOAD] = motor_overload;
		// [RQ5] Inverse-time overload fault
		cond_vec[`OFS_FN_INV_OVL] = inv_time_overload_fault;
		// [RQ6] Underload warning
		cond_vec[`OFS_FN_UNDERLOAD] = underload_warn;
		// [RQ7] Fan fault warning
		cond_vec[`OFS_FN_FAN] = fan_warn;
		// [RQ8] Overload and stall
		cond_vec[`OFS_FN_STALL] = motor_overload & stall;
		// [RQ9] DC overvoltage
		cond_vec[`OFS_FN_OVER_V] = dc_over_voltage;
		// [RQ10] DC low voltage
		cond_vec[`OFS_FN_LOW_V] = dc_low_voltage;
		// [RQ11] Drive overheat
		cond_vec[`OFS_FN_OVERHEAT] = drive_overheat;
		// [RQ12] Any command loss
		cond_vec[`OFS_FN_LOST_CMD] = analog_cmd_lost | comm_cmd_lost |
			option_cmd_lost;
		// [RQ13] Run, no DC braking
		cond_vec[`OFS_FN_RUN] = run_cmd & output_voltage_on & ~dc_braking;
		// [RQ14] Fully stopped
		cond_vec[`OFS_FN_STOP] = ~run_cmd & ~output_voltage_on;
		// [RQ15] Steady running speed
		cond_vec[`OFS_FN_STEADY] = run_cmd & output_voltage_on &
			~accelerating & ~decelerating;
		// [RQ16] Drive line supply
		cond_vec[`OFS_FN_DRIVE_LINE] = motor_on_drive_line;
		// [RQ17] Mains line supply
		cond_vec[`OFS_FN_MAINS_LINE] = motor_on_mains;
		// [RQ18] Speed search active
		cond_vec[`OFS_FN_SPD_SEARCH] = speed_search_active;
		// [RQ19] Standby ready
		cond_vec[`OFS_FN_READY] = ready_standby;
		// [RQ20] Delay timer output
		cond_vec[`OFS_FN_TIMER] = io_timer_out;
		// [RQ21] Fault trip latched upstream
		cond_vec[`OFS_FN_TRIP] = fault_tripped;
		// [RQ22] Analog on/off compare
		cond_vec[`OFS_FN_ONOFF] = analog_onoff_out;
	end

	////////////////////////////////////////////////////////////////////
	// Per-output code register, decoder and output flop
	genvar gi;
	generate
		for (gi = 0; gi < N; gi = gi + 1) begin : gen_out
			reg [SEL_W-1:0] sel_ff; // Selection code
			reg out_ff; // Registered output level
			wire pick; // Decoded condition
			wire hit; // This word addressed

			assign hit = wr_fire && wr_sel_hit &&
				(aw_addr_ff[3:2] == gi[1:0]);

			// Code register, low byte lane only
			always @(posedge aclk) begin
				if (!aresetn) begin
					sel_ff <= RST_SEL[gi*SEL_W +: SEL_W];
				end else if (hit && w_strb_ff[0]) begin
					sel_ff <= w_data_ff[SEL_W-1:0];
				end
			end

			// [RQ1] Independent code per output
			ofs_sel #(
				.SEL_W(SEL_W),
				.FN_NUM(FN_NUM)
			) u_sel (
				.sel_code(sel_ff),
				.cond_vec(cond_vec),
				.sel_out(pick)
			);

			// Output flop; off during reset so loads stay idle
			always @(posedge aclk) begin
				if (!aresetn) begin
					out_ff <= 1'b0;
				end else begin
					out_ff <= pick;
				end
			end

			assign sel_w[gi] = sel_ff;
			assign out_vec[gi] = out_ff;
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// Read channel: one answer per address, one cycle later
	reg [31:0] rd_mux;
	reg rd_ok;
	always @* begin
		rd_mux = 32'h00000000;
		rd_ok = 1'b1;
		case (s_axi_araddr)
			`OFS_REG_SEL_MAIN: begin
				rd_mux[SEL_W-1:0] = sel_w[0];
			end
			`OFS_REG_SEL_TR: begin
				rd_mux[SEL_W-1:0] = sel_w[1];
			end
			`OFS_REG_SEL_EXT_A: begin
				rd_mux[SEL_W-1:0] = sel_w[2];
			end
			`OFS_REG_SEL_EXT_B: begin
				rd_mux[SEL_W-1:0] = sel_w[3];
			end
			`OFS_REG_DET_FREQ: begin
				rd_mux[FREQ_W-1:0] = det_freq_ff;
			end
			`OFS_REG_DET_BAND: begin
				rd_mux[FREQ_W-1:0] = det_band_ff;
			end
			`OFS_REG_STATUS: begin
				// Live output levels and the reach state
				rd_mux[`OFS_ST_OUT_LSB +: N] = out_vec;
				rd_mux[`OFS_ST_REACH_BIT] = reach_ff;
			end
			default: begin
				// Unmapped: zero data, slave error
				rd_ok = 1'b0;
			end
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			arready_ff <= 1'b1;
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h00000000;
			rresp_ff <= `OFS_RESP_OKAY;
		end else if (s_axi_arvalid && arready_ff) begin
			// Take address, answer next edge
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b1;
			rdata_ff <= rd_mux;
			rresp_ff <= rd_ok ? `OFS_RESP_OKAY : `OFS_RESP_SLVERR;
		end else if (rvalid_ff && s_axi_rready) begin
			// Answer taken, reopen
			rvalid_ff <= 1'b0;
			arready_ff <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Port drive, all from flops
	assign s_axi_awready = awready_ff;
	assign s_axi_wready = wready_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_arready = arready_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;
	assign main_relay = out_vec[0];
	assign open_collector_output = out_vec[1];
	assign ext_relay_a = out_vec[2];
	assign ext_relay_b = out_vec[3];

endmodule // ofs_top

// File: ofs_loads.sv
// Relay and load model hanging on the four digital outputs
module ofs_loads (
	input wire logic aclk,
	input wire logic [3:0] coil,
	output logic [3:0] contact_ff
);
	timeunit 1ns;
	timeprecision 1ns;
	// Contacts lag the coils a cycle, like a slow armature
	always @(posedge aclk) begin
		contact_ff <= coil;
	end
endmodule // ofs_loads

// File: ofs_checker.sv
// Port-level checker for the output selector, bound onto ofs_top
module ofs_checker (
	input wire aclk,
	input wire aresetn,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire run_cmd,
	input wire output_voltage_on,
	input wire dc_braking,
	input wire fault_tripped,
	input wire main_relay,
	input wire open_collector_output,
	input wire ext_relay_a,
	input wire ext_relay_b
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic [7:0] aw_ff; // Latched write address
	logic [5:0] d_ff; // Latched code data
	logic st_ff; // Lane 0 strobe
	logic [5:0] code_ff; // Shadow of the main relay code
	////////////////////////////////////////////////////////////////////
	// Shadow tracks the code only at the B handshake, so it is trusted
	// only while no write is in flight (awready high)
	always @(posedge aclk) begin
		if (!aresetn) begin
			code_ff <= 6'h1D;
		end else begin
			if (s_axi_awvalid && s_axi_awready)
				aw_ff <= s_axi_awaddr;
			if (s_axi_wvalid && s_axi_wready) begin
				d_ff <= s_axi_wdata[5:0];
				st_ff <= s_axi_wstrb[0];
			end
			if (s_axi_bvalid && s_axi_bready && aw_ff == 8'h00 && st_ff)
				code_ff <= d_ff;
		end
	end
	////////////////////////////////////////////////////////////////////
	chk_trip_follow: assert property (
		s_axi_awready && code_ff == 6'h1D |=> main_relay == $past(fault_tripped))
		else $error("Trip output mismatch");
	chk_run_level: assert property (
		s_axi_awready && code_ff == 6'h0E |=> main_relay ==
		$past(run_cmd && output_voltage_on && !dc_braking))
		else $error("Run output mismatch");
	chk_undef_off: assert property (
		s_axi_awready && !(code_ff inside {[4:19], 22, 28, 29, 34})
		|=> !main_relay) else $error("Undefined code drives output");
	chk_reset_idle: assert property (disable iff (1'b0)
		!aresetn |=> !main_relay && !open_collector_output && !ext_relay_a
		&& !ext_relay_b && s_axi_awready && s_axi_arready && !s_axi_bvalid)
		else $error("Reset state wrong");
	chk_wr_answer: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:2] s_axi_bvalid) else $error("Write answer late");
	chk_b_stands: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("Write answer dropped");
	chk_rd_answer: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("Read answer late");
	chk_r_stands: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("Read data not held");
	chk_wr_busy: assert property (
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("Write taken while answering");
	cov_wr: cover property (s_axi_bvalid && s_axi_bready);
	cov_rd: cover property (s_axi_rvalid && s_axi_rready);
	cov_reach: cover property (code_ff == 6'h04 && main_relay);
endmodule // ofs_checker

bind ofs_top ofs_checker i_chk (.aclk, .aresetn, .s_axi_awaddr,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
	.s_axi_rready, .run_cmd, .output_voltage_on, .dc_braking,
	.fault_tripped, .main_relay, .open_collector_output, .ext_relay_a,
	.ext_relay_b);

// File: output_function_selector_tb.sv
// Self-checking bench for the output function selector
module output_function_selector_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic aclk, aresetn, busy, reach_m;
	logic [4:0] st_m; // Reference status word: reach, four outputs
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, r;
	logic [3:0] s_axi_wstrb, exp_ff;
	logic s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_rready;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid;
	wire s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [3:0] o; // Main, transistor, ext A, ext B
	logic [15:0] op_freq, det_m, band_m;
	logic [22:0] v; // Detector flags, see connections
	logic [5:0] code_m [4]; // Reference selection codes
	int err_total, n_checks, quiet;
	wire [3:0] hs = {s_axi_rvalid, s_axi_arready, s_axi_bvalid,
		s_axi_awready & s_axi_wready};
	ofs_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .op_freq,
		.motor_overload(v[0]), .inv_time_overload_fault(v[1]),
		.underload_warn(v[2]), .fan_warn(v[3]), .stall(v[4]),
		.dc_over_voltage(v[5]), .dc_low_voltage(v[6]),
		.drive_overheat(v[7]), .analog_cmd_lost(v[8]),
		.comm_cmd_lost(v[9]), .option_cmd_lost(v[10]), .run_cmd(v[11]),
		.output_voltage_on(v[12]), .dc_braking(v[13]),
		.motor_on_drive_line(v[14]), .motor_on_mains(v[15]),
		.speed_search_active(v[16]), .ready_standby(v[17]),
		.io_timer_out(v[18]), .fault_tripped(v[19]),
		.analog_onoff_out(v[20]), .accelerating(v[21]),
		.decelerating(v[22]), .main_relay(o[0]),
		.open_collector_output(o[1]), .ext_relay_a(o[2]),
		.ext_relay_b(o[3]));
	ofs_loads i_load (.aclk, .coil(o), .contact_ff());
	initial begin
		aclk = 0;
		forever #5 aclk = ~aclk;
	end
	////////////////////////////////////////////////////////////////////
	// Reference output for one code
	function automatic logic f(logic [5:0] c, logic [22:0] x, logic q);
		case (c)
			4: f = q;
			5, 6, 7, 8: f = x[c - 5];
			9: f = x[0] & x[4];
			10, 11, 12: f = x[c - 5];
			13: f = |x[10:8];
			14: f = x[11] & x[12] & !x[13];
			15: f = !x[11] & !x[12];
			16: f = x[11] & x[12] & !x[21] & !x[22];
			17, 18, 19: f = x[c - 3];
			22: f = x[17];
			28, 29: f = x[c - 10];
			34: f = x[20];
			default: f = 0;
		endcase
	endfunction
	task finish_test;
		if (err_total == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Automatic: called from the monitor and the bus tasks in one step
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			err_total++;
			$display("[ERR] %0t seen %h exp %h", $time, s, e);
		end
	endtask
	// Bounded wait on one handshake, checked mid-cycle
	task wt(input int w);
		int n;
		n = 0;
		do begin
			@(negedge aclk);
			n++;
		end while (!hs[w] && n < 200);
		if (n >= 200) begin
			err_total++;
			finish_test();
		end
	endtask
	// Answer is stalled a cycle before bready goes high
	task wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, input logic [1:0] er);
		busy = 1;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		wt(0);
		@(posedge aclk);
		s_axi_awvalid <= 0;
		s_axi_wvalid <= 0;
		wt(1);
		chk(s_axi_bresp, er);
		@(posedge aclk);
		s_axi_bready <= 1;
		@(posedge aclk);
		s_axi_bready <= 0;
		busy = 0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		wt(2);
		@(posedge aclk);
		s_axi_arvalid <= 0;
		wt(3);
		chk(s_axi_rdata, a == 8'h18 ? 32'(st_m) : ed);
		chk(s_axi_rresp, er);
		@(posedge aclk);
		s_axi_rready <= 1;
		@(posedge aclk);
		s_axi_rready <= 0;
	endtask
	task rst;
		aresetn <= 0;
		repeat (16) @(posedge aclk);
		aresetn <= 1;
		code_m = '{6'h1D, 6'h0E, 6'h00, 6'h00};
		det_m = 16'h0BB8;
		band_m = 16'h03E8;
	endtask
	////////////////////////////////////////////////////////////////////
	// Random drive state; acceleration forced while registers settle
	always @(posedge aclk) begin
		r = $urandom;
		v <= r[22:0] | {busy || quiet > 0, 21'h0};
		op_freq <= (r[23] ? det_m : det_m - band_m / 2) - 16'h4
			+ 16'(r[26:24]);
	end
	// Reference model, one cycle behind the sampled inputs
	always @(posedge aclk) begin
		quiet <= busy ? 5 : (quiet > 0 ? quiet - 1 : 0);
		// Status as the slave latches it: levels before this edge
		st_m <= {reach_m, exp_ff};
		if (!aresetn) begin
			exp_ff <= 4'h0;
			reach_m <= 0;
		end else begin
			for (int i = 0; i < 4; i++)
				exp_ff[i] <= f(code_m[i], v, reach_m);
			if (v[21])
				reach_m <= op_freq >= det_m;
			else if (v[22])
				reach_m <= int'(op_freq) + band_m / 2 > det_m;
		end
	end
	always @(negedge aclk)
		if (aresetn && !busy && quiet == 0)
			for (int i = 0; i < 4; i++)
				chk(o[i], exp_ff[i]);
	////////////////////////////////////////////////////////////////////
	initial begin
		logic [23:0] c;
		logic [31:0] rv; // Own copy; r belongs to the stimulus process
		void'($urandom(32'hD71C));
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready, busy} = 0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 0;
		{err_total, n_checks} = 0;
		rst();
		rd(8'h00, 32'h1D, 2'h0);
		rd(8'h04, 32'h0E, 2'h0);
		rd(8'h08, 32'h00, 2'h0);
		rd(8'h0C, 32'h00, 2'h0);
		rd(8'h10, 32'h0BB8, 2'h0);
		rd(8'h14, 32'h03E8, 2'h0);
		rd(8'h1C, 32'h0, 2'h2);
		wr(8'h1C, 32'h5, 4'hF, 2'h2);
		wr(8'h02, 32'h5, 4'hF, 2'h2);
		wr(8'h18, 32'h5, 4'hF, 2'h0);
		wr(8'h00, 32'h5, 4'hE, 2'h0);
		rd(8'h00, 32'h1D, 2'h0);
		repeat (40) @(posedge aclk);
		// Every code on each output, all four different except at k 23 and 55 (ext A, ext B)
		for (int k = 0; k < 64; k++) begin
			c = {6'(k + 17), 6'(63 - k), 6'(k ^ 1), 6'(k)};
			for (int i = 0; i < 4; i++) begin
				wr(8'(4 * i), 32'(c[6 * i +: 6]), 4'hF, 2'h0);
				code_m[i] = c[6 * i +: 6];
			end
			if (k % 8 == 3) begin
				rv = 200 + $urandom % 5000;
				wr(8'h10, rv, 4'hF, 2'h0);
				det_m = rv[15:0];
				rv = 100 + $urandom % 2000;
				wr(8'h14, rv, 4'hF, 2'h0);
				band_m = rv[15:0];
			end
			repeat (30) @(posedge aclk);
			// Status word: live outputs and reach state
			rd(8'h18, 32'h0, 2'h0);
		end
		rst();
		rd(8'h00, 32'h1D, 2'h0);
		repeat (40) @(posedge aclk);
		finish_test();
	end
endmodule // output_function_selector_tb
